// ---- hw/lsmie_map.svh ----
// offsets, field positions and reset values of the execution slice
// assumes an apb slave with 32-bit data and byte addresses
`ifndef LSMIE_MAP_SVH
`define LSMIE_MAP_SVH

// apb byte offsets, one aligned word each
`define LSMIE_OFS_CMD   8'h00
`define LSMIE_OFS_ACC   8'h04
`define LSMIE_OFS_STAT  8'h08
`define LSMIE_OFS_PTR0  8'h0c
`define LSMIE_OFS_PTR1  8'h10
`define LSMIE_OFS_RES   8'h14

// status word bit positions
`define LSMIE_STAT_CARRY 0
`define LSMIE_STAT_NULL  1
`define LSMIE_STAT_BUSY  2

// command word width and largest legal operation code
`define LSMIE_CMD_W      21
`define LSMIE_OP_LAST    3'h4

// file addresses that stand for the two indirect data ports
`define LSMIE_IND0_FADDR 7'h00
`define LSMIE_IND1_FADDR 7'h01

// reset values
`define LSMIE_ACC_RST    8'h00
`define LSMIE_PTR_RST    16'h0000

`endif

// ---- hw/lsmie_pkg.sv ----
// types shared by the execution slice and its helpers
// assumes nothing beyond the map header for numbers
package lsmie_pkg;

	// operation codes of the command word
	typedef enum logic [2:0] {OP_OR, OP_LSL, OP_LSR, OP_MOV, OP_IND} lsmie_op_type;

	// pointer update modes of the indirect load
	typedef enum logic [1:0] {MODE_PRE_INC, MODE_PRE_DEC, MODE_POST_INC, MODE_POST_DEC} lsmie_mode_type;

	// command word as written over apb, msb first
	typedef struct packed {
		logic [5:0]    offset;
		lsmie_mode_type mode;
		logic          rel;
		logic          ptr_sel;
		logic [6:0]    faddr;
		logic          dest;
		lsmie_op_type  op;
	} lsmie_cmd_type;

	// alu answer
	typedef struct packed {
		logic [7:0] result;
		logic       carry;
		logic       carry_upd;
		logic       zero;
	} lsmie_alu_res_type;

	// request to the data memory
	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} lsmie_mem_req_type;

	// sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC} lsmie_state_type;

endpackage : lsmie_pkg

// ---- hw/lsmie_alu.sv ----
// combinational alu for or, shifts, move and indirect load
// assumes operands are stable while the sequencer executes
`timescale 1ns/100ps
module lsmie_alu (
	input  wire lsmie_pkg::lsmie_op_type      op,
	input  wire logic [7:0]                   acc,
	input  wire logic [7:0]                   fval,
	output lsmie_pkg::lsmie_alu_res_type      res
);
	wire logic [7:0] or_val;
	wire logic [7:0] shl_val;
	wire logic [7:0] shr_val;
	wire logic [7:0] sel_val;
	wire logic       is_shl;
	wire logic       is_shr;

	assign or_val  = acc | fval;
	assign shl_val = {fval[6:0], 1'b0};
	assign shr_val = {1'b0, fval[7:1]};
	assign is_shl  = (op == lsmie_pkg::OP_LSL);
	assign is_shr  = (op == lsmie_pkg::OP_LSR);

	// move and indirect load pass the fetched byte
	assign sel_val = (op == lsmie_pkg::OP_OR) ? or_val :
	                 is_shl ? shl_val :
	                 is_shr ? shr_val : fval;

	// carry from the bit shifted out
	assign res.result    = sel_val;
	assign res.carry     = is_shl ? fval[7] : fval[0];
	assign res.carry_upd = is_shl | is_shr;
	// null set only on zero result
	assign res.zero      = (sel_val == 8'h00);
endmodule : lsmie_alu

// ---- hw/lsmie_ptr.sv ----
// effective address and next value of one file select pointer
// assumes 16-bit pointers and a 6-bit signed offset
`timescale 1ns/100ps
module lsmie_ptr (
	input  wire logic [15:0]                  ptr,
	input  wire lsmie_pkg::lsmie_mode_type    mode,
	input  wire logic                         rel,
	input  wire logic [5:0]                   offset,
	output logic [15:0]                       eff,
	output logic [15:0]                       nxt
);
	wire logic [15:0] inc;
	wire logic [15:0] dec;
	wire logic [15:0] rel_addr;
	wire logic [15:0] step;
	wire logic        pre;

	assign inc      = ptr + 16'h0001;
	assign dec      = ptr - 16'h0001;
	assign rel_addr = ptr + {{10{offset[5]}}, offset};

	// mode picks direction and pre or post
	assign step = (mode == lsmie_pkg::MODE_PRE_INC || mode == lsmie_pkg::MODE_POST_INC) ? inc : dec;
	assign pre  = (mode == lsmie_pkg::MODE_PRE_INC || mode == lsmie_pkg::MODE_PRE_DEC);

	assign eff = rel ? rel_addr : (pre ? step : ptr);
	assign nxt = rel ? ptr : step;
endmodule : lsmie_ptr

// ---- hw/lsmie_exec.sv ----
// execution slice: or, shifts, move and indirect load of an 8-bit core
// assumes an apb master on mclk and a data memory that answers a read one cycle after mem_req.rd
//
// Functional notes
// - the or operation ors the accumulator with the file byte and updates only the null flag.
// - destination bit 0 writes the result to the accumulator, bit 1 back into the file byte.
// - the left shift puts bit 7 in carry, bits 6..0 into 7..1, zero into bit 0, and updates carry and null.
// - the right shift puts zero into bit 7, bits 7..1 into 6..0, bit 0 into carry, and updates carry and null.
// - the move copies the file byte to the destination and updates null; with bit 1 the byte stays unchanged.
// - the indirect load reads the byte at the chosen pointer's address into the accumulator and updates null.
// - the update mode picks pre-increment, pre-decrement, post-increment or post-decrement by one.
// - the relative form addresses pointer plus a signed offset of -32..31 and keeps the pointer.
// - the indirect data port holds no storage; accesses go to the address in its pointer.
// - each pointer spans 0000h..ffffh and wraps modulo 65536 on increment and decrement.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "lsmie_map.svh"
module lsmie_exec (
	input  wire logic                         mclk,
	input  wire logic                         rst,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [7:0]                   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic [31:0]                       prdata,
	output logic                              pready,
	output logic                              pslverr,
	output lsmie_pkg::lsmie_mem_req_type      mem_req,
	input  wire logic [7:0]                   mem_rdata
);
	// offset hit, used by every register decode
	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
		reg_hit = (a == ofs);
	endfunction : reg_hit

	// indirect ports map onto the pointers
	function automatic logic [15:0] file_to_data(input logic [6:0] f, input logic [15:0] p0,
	                                             input logic [15:0] p1);
		file_to_data = (f == `LSMIE_IND0_FADDR) ? p0 :
		               (f == `LSMIE_IND1_FADDR) ? p1 : {9'h000, f};
	endfunction : file_to_data

	lsmie_pkg::lsmie_state_type   state_r;
	lsmie_pkg::lsmie_state_type   state_nxt;
	lsmie_pkg::lsmie_cmd_type     cmd_r;
	lsmie_pkg::lsmie_mem_req_type mem_req_r;
	lsmie_pkg::lsmie_alu_res_type alu_res;
	logic [7:0]                   acc_r;
	logic [7:0]                   res_r;
	logic                         carry_r;
	logic                         null_r;
	logic [31:0]                  prdata_r;
	logic [15:0]                  ptr_r [2];

	wire lsmie_pkg::lsmie_cmd_type cmd_in;
	wire logic                     apb_access;
	wire logic                     apb_wr;
	wire logic                     busy;
	wire logic                     cmd_hit;
	wire logic                     op_ok;
	wire logic                     mapped;
	wire logic                     accept;
	wire logic                     exec;
	wire logic                     write_back;
	wire logic                     acc_load;
	wire logic [15:0]              sel_ptr;
	wire logic [15:0]              ind_eff;
	wire logic [15:0]              ind_nxt;
	wire logic [15:0]              data_addr;
	wire logic [31:0]              rd_mux;
	wire logic [1:0]               ptr_wr;
	wire logic [1:0]               ptr_step;

	// apb decode and handshake
	assign cmd_in     = lsmie_pkg::lsmie_cmd_type'(pwdata[`LSMIE_CMD_W-1:0]);
	assign apb_access = psel & penable;
	assign busy       = (state_r != lsmie_pkg::ST_IDLE) | mem_req_r.wr;
	assign cmd_hit    = reg_hit(paddr, `LSMIE_OFS_CMD);
	assign op_ok      = (pwdata[2:0] <= `LSMIE_OP_LAST);
	assign mapped     = cmd_hit | reg_hit(paddr, `LSMIE_OFS_ACC) | reg_hit(paddr, `LSMIE_OFS_STAT) |
	                    reg_hit(paddr, `LSMIE_OFS_PTR0) | reg_hit(paddr, `LSMIE_OFS_PTR1) |
	                    reg_hit(paddr, `LSMIE_OFS_RES);
	// a command write waits while an operation is in flight
	assign pready     = ~(psel & pwrite & cmd_hit & busy);
	// unmapped addresses, bad codes and writes to read-only words are errors
	assign pslverr    = apb_access & pready & (~mapped | (pwrite & cmd_hit & ~op_ok) |
	                    (pwrite & (reg_hit(paddr, `LSMIE_OFS_STAT) | reg_hit(paddr, `LSMIE_OFS_RES))));
	assign apb_wr     = apb_access & pready & pwrite;
	assign accept     = apb_wr & cmd_hit & op_ok;
	assign prdata     = prdata_r;

	// pointer helper for the indirect load
	assign sel_ptr = ptr_r[cmd_in.ptr_sel];
	lsmie_ptr u_ptr (
		.ptr    (sel_ptr),
		.mode   (cmd_in.mode),
		.rel    (cmd_in.rel),
		.offset (cmd_in.offset),
		.eff    (ind_eff),
		.nxt    (ind_nxt)
	);

	// indirect load uses the pointer address
	assign data_addr = (cmd_in.op == lsmie_pkg::OP_IND) ? ind_eff :
	                   file_to_data(cmd_in.faddr, ptr_r[0], ptr_r[1]);

	// pointer write and step enables
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ptr_en
			assign ptr_wr[g]   = apb_wr & reg_hit(paddr, g ? `LSMIE_OFS_PTR1 : `LSMIE_OFS_PTR0);
			assign ptr_step[g] = accept & (cmd_in.op == lsmie_pkg::OP_IND) & ~cmd_in.rel &
			                     (cmd_in.ptr_sel == 1'(g));
		end
	endgenerate

	// pointer storage, one word each
	generate
		for (g = 0; g < 2; g++) begin : g_ptr
			always_ff @(posedge mclk) begin
				if (rst) begin
					ptr_r[g] <= `LSMIE_PTR_RST;
				end else if (ptr_wr[g]) begin
					ptr_r[g] <= pwdata[15:0];
				end else if (ptr_step[g]) begin
					ptr_r[g] <= ind_nxt;
				end
			end
		end
	endgenerate

	// alu on the fetched byte
	lsmie_alu u_alu (
		.op   (cmd_r.op),
		.acc  (acc_r),
		.fval (mem_rdata),
		.res  (alu_res)
	);

	// execute decode
	assign exec       = (state_r == lsmie_pkg::ST_EXEC);
	// move with bit 1 only tests the byte
	// bit 1 writes the file byte back for or and the shifts
	assign write_back = exec & cmd_r.dest & (cmd_r.op != lsmie_pkg::OP_IND) & (cmd_r.op != lsmie_pkg::OP_MOV);
	assign acc_load   = exec & ((cmd_r.op == lsmie_pkg::OP_IND) | ~cmd_r.dest);

	// sequencer next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			lsmie_pkg::ST_IDLE: begin
				if (accept) begin
					state_nxt = lsmie_pkg::ST_READ;
				end
			end
			lsmie_pkg::ST_READ: state_nxt = lsmie_pkg::ST_EXEC;
			lsmie_pkg::ST_EXEC: state_nxt = lsmie_pkg::ST_IDLE;
			default:            state_nxt = lsmie_pkg::ST_IDLE;
		endcase
	end

	// sequencer state and latched command
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r <= lsmie_pkg::ST_IDLE;
			cmd_r   <= '0;
		end else begin
			state_r <= state_nxt;
			if (accept) begin
				cmd_r <= cmd_in;
			end
		end
	end

	// memory request: read at accept, write back after execute
	always_ff @(posedge mclk) begin
		if (rst) begin
			mem_req_r <= '0;
		end else if (accept) begin
			mem_req_r.addr <= data_addr;
			mem_req_r.rd   <= 1'b1;
			mem_req_r.wr   <= 1'b0;
		end else begin
			mem_req_r.rd <= 1'b0;
			mem_req_r.wr <= write_back;
			if (write_back) begin
				mem_req_r.wdata <= alu_res.result;
			end
		end
	end
	assign mem_req = mem_req_r;

	// accumulator: apb write or instruction result
	always_ff @(posedge mclk) begin
		if (rst) begin
			acc_r <= `LSMIE_ACC_RST;
		end else if (acc_load) begin
			acc_r <= alu_res.result;
		end else if (apb_wr & reg_hit(paddr, `LSMIE_OFS_ACC)) begin
			acc_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			null_r  <= 1'b0;
			carry_r <= 1'b0;
			res_r   <= 8'h00;
		end else if (exec) begin
			null_r <= alu_res.zero;
			res_r  <= alu_res.result;
			if (alu_res.carry_upd) begin
				carry_r <= alu_res.carry;
			end
		end
	end

	// read mux, captured in the setup phase
	assign rd_mux = reg_hit(paddr, `LSMIE_OFS_CMD)  ? {11'h000, cmd_r} :
	                reg_hit(paddr, `LSMIE_OFS_ACC)  ? {24'h000000, acc_r} :
	                reg_hit(paddr, `LSMIE_OFS_STAT) ? {29'h00000000, busy, null_r, carry_r} :
	                reg_hit(paddr, `LSMIE_OFS_PTR0) ? {16'h0000, ptr_r[0]} :
	                reg_hit(paddr, `LSMIE_OFS_PTR1) ? {16'h0000, ptr_r[1]} :
	                reg_hit(paddr, `LSMIE_OFS_RES)  ? {24'h000000, res_r} : 32'h00000000;

	// read data register
	always_ff @(posedge mclk) begin
		if (rst) begin
			prdata_r <= 32'h00000000;
		end else if (psel & ~penable) begin
			prdata_r <= rd_mux;
		end
	end

	// checks on the datapath and sequencing
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_ind_accept;
		accept && cmd_in.op == lsmie_pkg::OP_IND;
	endsequence

	sequence s_fetch;
		(state_r == lsmie_pkg::ST_READ && mem_req.rd) ##1 exec;
	endsequence

	a_or_to_acc: assert property (exec && cmd_r.op == lsmie_pkg::OP_OR && !cmd_r.dest |=>
		acc_r == ($past(acc_r) | $past(mem_rdata)) && $stable(carry_r))
		else $error("or result not in accumulator");

	a_dest_file_wr: assert property (exec && cmd_r.dest && cmd_r.op == lsmie_pkg::OP_OR |=>
		mem_req.wr && mem_req.addr == $past(mem_req.addr) && $stable(acc_r))
		else $error("file destination not written back");

	a_shl_carry: assert property (exec && cmd_r.op == lsmie_pkg::OP_LSL |=>
		carry_r == $past(mem_rdata[7]) && res_r == {$past(mem_rdata[6:0]), 1'b0})
		else $error("left shift wrong");

	a_shr_carry: assert property (exec && cmd_r.op == lsmie_pkg::OP_LSR |=>
		carry_r == $past(mem_rdata[0]) && res_r == {1'b0, $past(mem_rdata[7:1])})
		else $error("right shift wrong");

	a_mov_no_wr: assert property (exec && cmd_r.op == lsmie_pkg::OP_MOV && cmd_r.dest |=>
		!mem_req.wr && $stable(acc_r) && null_r == ($past(mem_rdata) == 8'h00))
		else $error("move test wrote memory");

	a_ind_load_acc: assert property (s_ind_accept |=> s_fetch ##1
		(acc_r == $past(mem_rdata)))
		else $error("indirect load did not reach accumulator");

	a_pre_inc_addr: assert property (accept && cmd_in.op == lsmie_pkg::OP_IND && !cmd_in.rel &&
		cmd_in.mode == lsmie_pkg::MODE_PRE_INC && !cmd_in.ptr_sel |=>
		mem_req.addr == ptr_r[0] && ptr_r[0] == $past(ptr_r[0]) + 16'h0001)
		else $error("pre-increment address wrong");

	a_post_dec_addr: assert property (accept && cmd_in.op == lsmie_pkg::OP_IND && !cmd_in.rel &&
		cmd_in.mode == lsmie_pkg::MODE_POST_DEC && cmd_in.ptr_sel |=>
		mem_req.addr == $past(ptr_r[1]) && ptr_r[1] == $past(ptr_r[1]) - 16'h0001)
		else $error("post-decrement address wrong");

	a_rel_keeps_ptr: assert property (s_ind_accept and (accept && cmd_in.rel) |=>
		$stable(ptr_r[0]) && $stable(ptr_r[1]) &&
		mem_req.addr == $past(sel_ptr) + {{10{$past(cmd_in.offset[5])}}, $past(cmd_in.offset)})
		else $error("relative form moved the pointer");

	a_ind_redirect: assert property (accept && cmd_in.op != lsmie_pkg::OP_IND &&
		cmd_in.faddr == `LSMIE_IND1_FADDR |=> mem_req.addr == $past(ptr_r[1]))
		else $error("indirect port not redirected");

	a_ptr_wrap: assert property (accept && cmd_in.op == lsmie_pkg::OP_IND && !cmd_in.rel &&
		cmd_in.mode == lsmie_pkg::MODE_POST_INC && !cmd_in.ptr_sel && ptr_r[0] == 16'hffff |=>
		ptr_r[0] == 16'h0000)
		else $error("pointer did not wrap");

	// null is worked out again from the operands, not from the stored result
	a_null_flag: assert property (exec |=> null_r ==
		(($past(cmd_r.op) == lsmie_pkg::OP_OR) ? (($past(acc_r) | $past(mem_rdata)) == 8'h00) :
		 ($past(cmd_r.op) == lsmie_pkg::OP_LSL) ? ($past(mem_rdata[6:0]) == 7'h00) :
		 ($past(cmd_r.op) == lsmie_pkg::OP_LSR) ? ($past(mem_rdata[7:1]) == 7'h00) :
		 ($past(mem_rdata) == 8'h00)))
		else $error("null flag disagrees with result");

	// further pointer, redirect and destination checks
	a_pre_dec_addr: assert property (accept && cmd_in.op == lsmie_pkg::OP_IND && !cmd_in.rel &&
		cmd_in.mode == lsmie_pkg::MODE_PRE_DEC && cmd_in.ptr_sel |=>
		mem_req.addr == ptr_r[1] && ptr_r[1] == $past(ptr_r[1]) - 16'h0001)
		else $error("pre-decrement address wrong");

	a_post_inc_addr: assert property (accept && cmd_in.op == lsmie_pkg::OP_IND && !cmd_in.rel &&
		cmd_in.mode == lsmie_pkg::MODE_POST_INC && !cmd_in.ptr_sel |=>
		mem_req.addr == $past(ptr_r[0]) && ptr_r[0] == $past(ptr_r[0]) + 16'h0001)
		else $error("post-increment address wrong");

	a_port0_redirect: assert property (accept && cmd_in.op != lsmie_pkg::OP_IND &&
		cmd_in.faddr == `LSMIE_IND0_FADDR |=> mem_req.addr == $past(ptr_r[0]) && $stable(ptr_r[0]))
		else $error("port zero not redirected");

	a_plain_faddr: assert property (accept && cmd_in.op != lsmie_pkg::OP_IND &&
		cmd_in.faddr > `LSMIE_IND1_FADDR |=>
		mem_req.addr == {9'h000, $past(cmd_in.faddr)} && $stable(ptr_r[0]) && $stable(ptr_r[1]))
		else $error("plain file address moved");

	a_lsl_file_wr: assert property (exec && cmd_r.dest && cmd_r.op == lsmie_pkg::OP_LSL |=>
		mem_req.wr && mem_req.wdata == {$past(mem_rdata[6:0]), 1'b0} && $stable(acc_r))
		else $error("left shift not written back");

	a_lsr_file_wr: assert property (exec && cmd_r.dest && cmd_r.op == lsmie_pkg::OP_LSR |=>
		mem_req.wr && mem_req.wdata == {1'b0, $past(mem_rdata[7:1])} && $stable(acc_r))
		else $error("right shift not written back");

	a_mov_to_acc: assert property (exec && cmd_r.op == lsmie_pkg::OP_MOV && !cmd_r.dest |=>
		acc_r == $past(mem_rdata) && !mem_req.wr &&
		$stable(carry_r))
		else $error("move did not reach accumulator");

	a_ind_keeps_carry: assert property (exec && cmd_r.op == lsmie_pkg::OP_IND |=>
		$stable(carry_r) && !mem_req.wr &&
		null_r == ($past(mem_rdata) == 8'h00))
		else $error("indirect load touched carry or memory");

	sequence s_rd_pulse;
		mem_req.rd ##1 (!mem_req.rd && !mem_req.wr);
	endsequence

	a_rd_pulse_once: assert property (s_ind_accept |=> s_rd_pulse)
		else $error("indirect read not a single pulse");

endmodule : lsmie_exec

// ---- verification/lsmie_exec_tb_top.sv ----
// self-checking bench for the execution slice: apb master, byte memory and result monitor
// assumes the map header and package of the design, one 20 MHz clock and a synchronous reset
`timescale 1ns/100ps
`include "lsmie_map.svh"
module lsmie_exec_tb_top;
	logic                         mclk, rst, psel, penable, pwrite, pready, pslverr, e_c, b2b;
	logic [7:0]                   paddr, mem_rdata, rnd, va, vf;
	logic [31:0]                  pwdata, prdata;
	logic [15:0]                  p0, p1;
	logic [33:0]                  ex;
	logic [24:0]                  mx;
	lsmie_pkg::lsmie_mem_req_type mem_req;
	logic [7:0]                   mem [0:65535];
	logic [33:0]                  apb_q [$];
	logic [24:0]                  mem_q [$];
	int                           err_total, total_checks, stall_seen;

	lsmie_exec u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_req(mem_req), .mem_rdata(mem_rdata));

	// clock source
	always #25 mclk = ~mclk;

	task chk(input logic [47:0] seen, input logic [47:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task test_done;
		if (err_total == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	function logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	function logic [31:0] cmd(input logic [2:0] op, input logic dst, input logic [6:0] fa, input logic ps,
		input logic rl, input logic [1:0] md, input logic [5:0] off);
		return {11'h000, off, md, rl, ps, fa, dst, op};
	endfunction : cmd

	// one apb transfer; b2b keeps psel up so the next setup follows at once
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic ee, input logic [31:0] ed);
		apb_q.push_back({wr, ee, ed});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		penable <= 1'b0;
		if (!b2b) begin
			psel <= 1'b0;
			@(posedge mclk);
		end
	endtask : apb

	// file operation with expected accumulator, status, result and memory traffic
	task do_file(input logic [2:0] op, input logic dst, input logic [6:0] fa, input logic [7:0] a, input logic [7:0] f);
		logic [15:0] ea;
		logic [7:0]  r;
		ea = (fa == 7'h00) ? p0 : (fa == 7'h01) ? p1 : {9'h000, fa};
		mem[ea] = f;
		r = (op == 3'h0) ? (a | f) : (op == 3'h1) ? {f[6:0], 1'b0} : (op == 3'h2) ? {1'b0, f[7:1]} : f;
		if (op == 3'h1)
			e_c = f[7];
		if (op == 3'h2)
			e_c = f[0];
		apb(1'b1, `LSMIE_OFS_ACC, {24'h000000, a}, 1'b0, 32'h0);
		mem_q.push_back({1'b0, ea, 8'h00});
		if (dst && op != 3'h3)
			mem_q.push_back({1'b1, ea, r});
		apb(1'b1, `LSMIE_OFS_CMD, cmd(op, dst, fa, 1'b0, 1'b0, 2'h0, 6'h00), 1'b0, 32'h0);
		repeat (4) @(posedge mclk);
		apb(1'b0, `LSMIE_OFS_ACC, 32'h0, 1'b0, {24'h000000, dst ? a : r});
		apb(1'b0, `LSMIE_OFS_STAT, 32'h0, 1'b0, {29'h0, 1'b0, r == 8'h00, e_c});
		apb(1'b0, `LSMIE_OFS_RES, 32'h0, 1'b0, {24'h000000, r});
	endtask : do_file

	// indirect load through one pointer
	task do_ind(input logic ps, input logic rl, input logic [1:0] md, input logic [5:0] off, input logic [15:0] pv,
		input logic [7:0] d);
		logic [15:0] ea, nx;
		ea = rl ? pv + {{10{off[5]}}, off} : (md == 2'h0) ? pv + 16'h0001 : (md == 2'h1) ? pv - 16'h0001 : pv;
		nx = rl ? pv : md[0] ? pv - 16'h0001 : pv + 16'h0001;
		mem[ea] = d;
		apb(1'b1, ps ? `LSMIE_OFS_PTR1 : `LSMIE_OFS_PTR0, {16'h0000, pv}, 1'b0, 32'h0);
		mem_q.push_back({1'b0, ea, 8'h00});
		apb(1'b1, `LSMIE_OFS_CMD, cmd(3'h4, 1'b0, 7'h05, ps, rl, md, off), 1'b0, 32'h0);
		repeat (4) @(posedge mclk);
		apb(1'b0, `LSMIE_OFS_ACC, 32'h0, 1'b0, {24'h000000, d});
		apb(1'b0, `LSMIE_OFS_STAT, 32'h0, 1'b0, {29'h0, 1'b0, d == 8'h00, e_c});
		apb(1'b0, ps ? `LSMIE_OFS_PTR1 : `LSMIE_OFS_PTR0, 32'h0, 1'b0, {16'h0000, nx});
	endtask : do_ind

	// byte memory: read data valid the cycle after rd, otherwise toggling
	always @(posedge mclk) begin
		if (mem_req.rd)
			mem_rdata <= mem[mem_req.addr];
		else
			mem_rdata <= ~mem_rdata;
		if (mem_req.wr)
			mem[mem_req.addr] <= mem_req.wdata;
	end

	// monitor: each completed transfer or memory request takes the oldest note
	always @(posedge mclk) begin
		if (!rst && psel && penable && !pready)
			stall_seen++;
		if (!rst && psel && penable && pready) begin
			ex = apb_q.pop_front();
			chk({15'h0000, pslverr, ex[33] ? ex[31:0] : prdata}, {15'h0000, ex[32:0]});
		end
		if (mem_req.rd || mem_req.wr) begin
			mx = mem_q.pop_front();
			chk({23'h0, mem_req.wr, mem_req.addr, mem_req.wr ? mem_req.wdata : 8'h00}, {23'h0, mx});
		end
	end

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		test_done();
	end

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		{psel, penable, pwrite, b2b, e_c} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		mem_rdata = 8'h00;
		{p0, p1} = 32'h0;
		rnd = 8'h3a;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		// reset values and an unmapped read
		for (int i = 0; i < 6; i++)
			apb(1'b0, 8'(i * 4), 32'h0, 1'b0, 32'h0);
		apb(1'b0, 8'h18, 32'h0, 1'b1, 32'h0);
		// or, shifts and move, both destinations, zero results in second half
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			va = (i >= 8) ? 8'h00 : rnd;
			rnd = lfsr(rnd);
			vf = (i < 8) ? rnd : (i % 4 == 1) ? 8'h80 : (i % 4 == 2) ? 8'h01 : 8'h00;
			do_file(3'(i % 4), 1'((i / 4) % 2), 7'h10 + 7'(i), va, vf);
		end
		// data ports redirect through both pointers, pointer 0 kept
		p0 = 16'h1234;
		apb(1'b1, `LSMIE_OFS_PTR0, {16'h0000, p0}, 1'b0, 32'h0);
		do_file(3'h0, 1'b1, 7'h00, 8'h5a, 8'h81);
		apb(1'b0, `LSMIE_OFS_PTR0, 32'h0, 1'b0, 32'h00001234);
		p1 = 16'h4321;
		apb(1'b1, `LSMIE_OFS_PTR1, {16'h0000, p1}, 1'b0, 32'h0);
		do_file(3'h3, 1'b0, 7'h01, 8'h00, 8'h9c);
		// every mode, wraps and offset bounds
		do_ind(1'b0, 1'b0, 2'h0, 6'h00, 16'hffff, 8'h00);
		do_ind(1'b1, 1'b0, 2'h1, 6'h00, 16'h0000, 8'h3c);
		do_ind(1'b0, 1'b0, 2'h2, 6'h00, 16'hffff, 8'hc3);
		do_ind(1'b1, 1'b0, 2'h3, 6'h00, 16'h0000, 8'h7e);
		do_ind(1'b0, 1'b1, 2'h3, 6'h20, 16'h0010, 8'h11);
		do_ind(1'b1, 1'b1, 2'h0, 6'h1f, 16'hfff0, 8'h22);
		// refused writes leave state alone
		apb(1'b1, `LSMIE_OFS_STAT, 32'h7, 1'b1, 32'h0);
		apb(1'b1, `LSMIE_OFS_RES, 32'hff, 1'b1, 32'h0);
		apb(1'b1, `LSMIE_OFS_CMD, 32'h5, 1'b1, 32'h0);
		apb(1'b0, `LSMIE_OFS_CMD, 32'h0, 1'b0, cmd(3'h4, 1'b0, 7'h05, 1'b1, 1'b1, 2'h0, 6'h1f));
		apb(1'b0, `LSMIE_OFS_ACC, 32'h0, 1'b0, 32'h22);
		// back to back commands: the second waits while busy
		mem[16'h0020] = 8'hf0;
		mem[16'h0021] = 8'h81;
		apb(1'b1, `LSMIE_OFS_ACC, 32'h0f, 1'b0, 32'h0);
		mem_q.push_back({1'b0, 16'h0020, 8'h00});
		mem_q.push_back({1'b0, 16'h0021, 8'h00});
		b2b = 1'b1;
		apb(1'b1, `LSMIE_OFS_CMD, cmd(3'h0, 1'b0, 7'h20, 1'b0, 1'b0, 2'h0, 6'h00), 1'b0, 32'h0);
		b2b = 1'b0;
		apb(1'b1, `LSMIE_OFS_CMD, cmd(3'h1, 1'b0, 7'h21, 1'b0, 1'b0, 2'h0, 6'h00), 1'b0, 32'h0);
		repeat (4) @(posedge mclk);
		apb(1'b0, `LSMIE_OFS_ACC, 32'h0, 1'b0, 32'h02);
		apb(1'b0, `LSMIE_OFS_STAT, 32'h0, 1'b0, 32'h01);
		repeat (2) @(posedge mclk);
		chk(48'(stall_seen != 0), 48'h1);
		chk(48'(mem_q.size() + apb_q.size()), 48'h0);
		test_done();
	end
endmodule : lsmie_exec_tb_top
